// File: pif_flags.sv
// What this block does
// - One enable bit per peripheral event source
// - Enable and flag bits writable, reset zero
// - Parallel port access sets sticky flag
// - No async serial: flag bits 5,4 zero
// - Sync serial completion sets software-cleared flag
// - Capture mode: each capture sets unit flag
// - Compare mode: match sets same unit flag
// - Global control mirrored in every bank
// - Global control resets 0; bit0 kept elsewhere
// - Pin and watchdog resets are other-resets
// - Selected external pin edge sets flag
// - Timer zero wrap sets its flag
// - Port B upper change sets flag
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pif_flags #(
	parameter bit HAS_ASYNC_SERIAL = 1'b1
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        externalResetPin_n,
	input  wire logic        watchdogTimeout,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        parallelPortAccess,
	input  wire logic        asyncReceiveEvent,
	input  wire logic        asyncTransmitEvent,
	input  wire logic        syncSerialDone,
	input  wire logic [1:0]  capcompMode,
	input  wire logic        capcompCapture,
	input  wire logic        capcompCompareMatch,
	input  wire logic        timerTwoMatch,
	input  wire logic        timerOneOverflow,
	input  wire logic        externalInterruptPin,
	input  wire logic [7:0]  timerZeroCount,
	input  wire logic [3:0]  portChangeInputs,
	output var  logic        irqRequest
);

	logic [7:0] flags_q;
	logic [7:0] enables_q;
	logic [7:0] globalCtrl_q;
	logic [7:0] option_q;
	logic [7:0] periphSet;
	logic [7:0] flagMask;
	logic [7:0] globalSet;
	logic [7:0] rdByte;
	logic [8:0] addrIdx_q;
	logic       wrPend_q;
	logic       rdPend_q;
	logic       otherReset;
	logic       addrTaken;
	logic       extEdgeEvent;
	logic       timerZeroWrap;
	logic       portChangeEvent;
	logic       wrGlobal;
	logic       wrFlags;
	logic       wrEnables;
	logic       wrOption;
	logic [7:0] wrByte;
	logic [7:0] flags_d;
	logic [7:0] globalCtrl_d;
	logic [7:0] periphPending;
	logic       coreRequest;
	logic       periphRequest;

	assign otherReset = !externalResetPin_n || watchdogTimeout;

	pif_event_sense u_sense (
		.core_clk             (core_clk),
		.rst_n                (rst_n),
		.externalInterruptPin (externalInterruptPin),
		.edgeSelectOption     (option_q[pif_pkg::BIT_EDGE_SELECT]),
		.timerZeroCount       (timerZeroCount),
		.portChangeInputs     (portChangeInputs),
		.extEdgeEvent         (extEdgeEvent),
		.timerZeroWrap        (timerZeroWrap),
		.portChangeEvent      (portChangeEvent)
	);

	// Bus access: writes zero-wait, reads one wait state
	assign addrTaken = hsel && hready && htrans == pif_pkg::HTRANS_NONSEQ;

	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			addrIdx_q <= 9'h000;
			wrPend_q  <= 1'b0;
			rdPend_q  <= 1'b0;
		end else begin
			wrPend_q <= addrTaken && hwrite;
			rdPend_q <= addrTaken && !hwrite;
			if (addrTaken) begin
				addrIdx_q <= haddr[pif_pkg::ADDR_WIDTH-1:pif_pkg::IDX_LSB];
			end
		end
	end

	assign wrByte    = hwdata[7:0];
	assign wrGlobal  = wrPend_q && (addrIdx_q == pif_pkg::IDX_GLOBAL_CTRL_B0
		|| addrIdx_q == pif_pkg::IDX_GLOBAL_CTRL_B1
		|| addrIdx_q == pif_pkg::IDX_GLOBAL_CTRL_B2
		|| addrIdx_q == pif_pkg::IDX_GLOBAL_CTRL_B3);
	assign wrFlags   = wrPend_q && addrIdx_q == pif_pkg::IDX_EVENT_FLAGS;
	assign wrEnables = wrPend_q && addrIdx_q == pif_pkg::IDX_EVENT_ENABLES;
	assign wrOption  = wrPend_q && addrIdx_q == pif_pkg::IDX_OPTION_CTRL;

	// Implemented flag bits; bit 6 never stored
	assign flagMask = HAS_ASYNC_SERIAL ? pif_pkg::PERIPH_IMPL_MASK
		: (pif_pkg::PERIPH_IMPL_MASK & ~pif_pkg::ASYNC_BITS_MASK);

	// Event sets, independent of enables
	always_comb begin
		periphSet = 8'h00;
		periphSet[pif_pkg::BIT_PARALLEL_PORT]  = parallelPortAccess;
		periphSet[pif_pkg::BIT_ASYNC_RECEIVE]  = asyncReceiveEvent;
		periphSet[pif_pkg::BIT_ASYNC_TRANSMIT] = asyncTransmitEvent;
		periphSet[pif_pkg::BIT_SYNC_SERIAL]    = syncSerialDone;
		periphSet[pif_pkg::BIT_CAPCOMP_ONE] =
			(capcompMode == pif_pkg::CAPCOMP_CAPTURE && capcompCapture)
			|| (capcompMode == pif_pkg::CAPCOMP_COMPARE
			&& capcompCompareMatch);
		periphSet[pif_pkg::BIT_TIMER_TWO] = timerTwoMatch;
		periphSet[pif_pkg::BIT_TIMER_ONE] = timerOneOverflow;
	end

	always_comb begin
		globalSet = 8'h00;
		globalSet[pif_pkg::BIT_TZERO_FLAG]    = timerZeroWrap;
		globalSet[pif_pkg::BIT_EXT_EDGE_FLAG] = extEdgeEvent;
		globalSet[pif_pkg::BIT_PORT_CHG_FLAG] = portChangeEvent;
	end

	// Per-bit next flag value; an event beats a clearing write
	for (genvar b = 0; b < 8; b++) begin : g_flag
		assign flags_d[b] = flagMask[b] && (periphSet[b]
			|| (wrFlags ? wrByte[b] : flags_q[b]));
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			flags_q <= pif_pkg::FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			enables_q <= pif_pkg::ENABLES_RESET;
		end else if (wrEnables) begin
			enables_q <= wrByte & pif_pkg::PERIPH_IMPL_MASK;
		end
	end

	// Enable bits follow writes; flag bits also latch events
	assign globalCtrl_d[7:pif_pkg::BIT_PORT_CHG_EN] = wrGlobal
		? wrByte[7:pif_pkg::BIT_PORT_CHG_EN]
		: globalCtrl_q[7:pif_pkg::BIT_PORT_CHG_EN];
	for (genvar b = 0; b <= pif_pkg::BIT_TZERO_FLAG; b++) begin : g_core_flag
		assign globalCtrl_d[b] = globalSet[b]
			|| (wrGlobal ? wrByte[b] : globalCtrl_q[b]);
	end

	// Global control: bit 0 survives the other resets
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			globalCtrl_q <= pif_pkg::GLOBAL_CTRL_RESET;
		end else if (otherReset) begin
			globalCtrl_q <= {pif_pkg::GLOBAL_CTRL_RESET[7:1],
				globalCtrl_q[0]};
		end else begin
			globalCtrl_q <= globalCtrl_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			option_q <= pif_pkg::OPTION_RESET;
		end else if (wrOption) begin
			option_q <= wrByte & pif_pkg::OPTION_IMPL_MASK;
		end
	end

	// Read mux, all bank mirrors to one register
	always_comb begin
		case (addrIdx_q)
			pif_pkg::IDX_GLOBAL_CTRL_B0,
			pif_pkg::IDX_GLOBAL_CTRL_B1,
			pif_pkg::IDX_GLOBAL_CTRL_B2,
			pif_pkg::IDX_GLOBAL_CTRL_B3: rdByte = globalCtrl_q;
			pif_pkg::IDX_EVENT_FLAGS:    rdByte = flags_q;
			pif_pkg::IDX_EVENT_ENABLES:  rdByte = enables_q;
			pif_pkg::IDX_OPTION_CTRL:    rdByte = option_q;
			default:                     rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= pif_pkg::HRESP_OKAY;
		end else begin
			hresp <= pif_pkg::HRESP_OKAY;
			if (addrTaken && !hwrite) begin
				hreadyout <= 1'b0;
			end else begin
				hreadyout <= 1'b1;
			end
			if (rdPend_q) begin
				hrdata <= {24'h00_0000, rdByte};
			end
		end
	end

	// Core sources pair enable and flag inside global control
	assign coreRequest = (globalCtrl_q[pif_pkg::BIT_TZERO_EN]
		&& globalCtrl_q[pif_pkg::BIT_TZERO_FLAG])
		|| (globalCtrl_q[pif_pkg::BIT_EXT_EDGE_EN]
		&& globalCtrl_q[pif_pkg::BIT_EXT_EDGE_FLAG])
		|| (globalCtrl_q[pif_pkg::BIT_PORT_CHG_EN]
		&& globalCtrl_q[pif_pkg::BIT_PORT_CHG_FLAG]);

	// Peripheral sources need their own enable and the group enable
	assign periphPending = flags_q & enables_q;
	assign periphRequest = globalCtrl_q[pif_pkg::BIT_PERIPH_EN]
		&& |periphPending;

	// Interrupt request to the core, registered
	always_ff @(posedge core_clk) begin
		if (!rst_n || otherReset) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= globalCtrl_q[pif_pkg::BIT_GLOBAL_EN]
				&& (coreRequest || periphRequest);
		end
	end

endmodule : pif_flags
`default_nettype wire

// File: pif_pkg.sv
`default_nettype none
package pif_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [8:0] IDX_GLOBAL_CTRL_B0 = 9'h00b;
	localparam logic [8:0] IDX_GLOBAL_CTRL_B1 = 9'h08b;
	localparam logic [8:0] IDX_GLOBAL_CTRL_B2 = 9'h10b;
	localparam logic [8:0] IDX_GLOBAL_CTRL_B3 = 9'h18b;
	localparam logic [8:0] IDX_EVENT_FLAGS    = 9'h00c;
	localparam logic [8:0] IDX_EVENT_ENABLES  = 9'h08c;
	localparam logic [8:0] IDX_OPTION_CTRL    = 9'h181;

	localparam int ADDR_WIDTH = 11;
	localparam int IDX_LSB    = 2;

	// Peripheral flag and enable bit positions
	localparam int BIT_PARALLEL_PORT  = 7;
	localparam int BIT_RESERVED       = 6;
	localparam int BIT_ASYNC_RECEIVE  = 5;
	localparam int BIT_ASYNC_TRANSMIT = 4;
	localparam int BIT_SYNC_SERIAL    = 3;
	localparam int BIT_CAPCOMP_ONE    = 2;
	localparam int BIT_TIMER_TWO      = 1;
	localparam int BIT_TIMER_ONE      = 0;

	// Global control bit positions
	localparam int BIT_GLOBAL_EN     = 7;
	localparam int BIT_PERIPH_EN     = 6;
	localparam int BIT_TZERO_EN      = 5;
	localparam int BIT_EXT_EDGE_EN   = 4;
	localparam int BIT_PORT_CHG_EN   = 3;
	localparam int BIT_TZERO_FLAG    = 2;
	localparam int BIT_EXT_EDGE_FLAG = 1;
	localparam int BIT_PORT_CHG_FLAG = 0;

	// Option control: edge select only
	localparam int BIT_EDGE_SELECT = 6;

	localparam logic [7:0] PERIPH_IMPL_MASK  = 8'hbf;
	localparam logic [7:0] ASYNC_BITS_MASK   = 8'h30;
	localparam logic [7:0] OPTION_IMPL_MASK  = 8'h40;
	localparam logic [7:0] FLAGS_RESET       = 8'h00;
	localparam logic [7:0] ENABLES_RESET     = 8'h00;
	localparam logic [7:0] GLOBAL_CTRL_RESET = 8'h00;
	localparam logic [7:0] OPTION_RESET      = 8'h40;
	localparam logic [7:0] TIMER_ZERO_MAX    = 8'hff;
	localparam logic [7:0] TIMER_ZERO_MIN    = 8'h00;

	// Capture/compare unit one modes
	localparam logic [1:0] CAPCOMP_CAPTURE = 2'h1;
	localparam logic [1:0] CAPCOMP_COMPARE = 2'h2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : pif_pkg
`default_nettype wire

// File: pif_event_sense.sv
`timescale 1ns/1ps
`default_nettype none
module pif_event_sense (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       externalInterruptPin,
	input  wire logic       edgeSelectOption,
	input  wire logic [7:0] timerZeroCount,
	input  wire logic [3:0] portChangeInputs,
	output var  logic       extEdgeEvent,
	output var  logic       timerZeroWrap,
	output var  logic       portChangeEvent
);

	logic       primed_q;
	logic       pinPrev_q;
	logic [7:0] countPrev_q;
	logic [3:0] portPrev_q;

	// History starts valid one cycle after reset release
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			primed_q    <= 1'b0;
			pinPrev_q   <= 1'b0;
			countPrev_q <= 8'h00;
			portPrev_q  <= 4'h0;
		end else begin
			primed_q    <= 1'b1;
			pinPrev_q   <= externalInterruptPin;
			countPrev_q <= timerZeroCount;
			portPrev_q  <= portChangeInputs;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			extEdgeEvent    <= 1'b0;
			timerZeroWrap   <= 1'b0;
			portChangeEvent <= 1'b0;
		end else begin
			extEdgeEvent <= primed_q && (edgeSelectOption ?
				(externalInterruptPin && !pinPrev_q) :
				(!externalInterruptPin && pinPrev_q));
			timerZeroWrap <= primed_q
				&& countPrev_q == pif_pkg::TIMER_ZERO_MAX
				&& timerZeroCount == pif_pkg::TIMER_ZERO_MIN;
			portChangeEvent <= primed_q
				&& (portChangeInputs != portPrev_q);
		end
	end

endmodule : pif_event_sense
`default_nettype wire

// File: pif_flags_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pif_flags_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        externalResetPin_n,
	input wire logic        watchdogTimeout,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irqRequest
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd;
		hsel && hready && htrans == pif_pkg::HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence s_wr;
		hsel && hready && htrans == pif_pkg::HTRANS_NONSEQ && hwrite;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd; s_rd |=> s_wait; endproperty
	property p_wr; s_wr |=> hreadyout; endproperty
	property p_hi; $rose(hreadyout) |-> hrdata[31:8] == 24'h0; endproperty
	property p_hrd;
		$changed(hrdata) |-> $past(!hreadyout) || $past(!externalResetPin_n)
			|| $past(watchdogTimeout);
	endproperty
	property p_okay; hresp == pif_pkg::HRESP_OKAY; endproperty
	property p_por;
		!$past(rst_n) |-> !irqRequest && hrdata == 32'h0;
	endproperty
	property p_ext; !externalResetPin_n |=> !irqRequest && hreadyout; endproperty
	property p_wdt; watchdogTimeout |=> !irqRequest && hrdata == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read wait state wrong");
	a_wr: assert property (p_wr) else $error("write stalled");
	a_hi: assert property (p_hi) else $error("upper read bits set");
	a_hrd: assert property (p_hrd) else $error("read data moved");
	a_okay: assert property (p_okay) else $error("error response");
	a_por: assert property (p_por) else $error("bad power-on state");
	a_ext: assert property (p_ext) else $error("pin reset ignored");
	a_wdt: assert property (p_wdt) else $error("watchdog ignored");
endmodule : pif_flags_chk
bind pif_flags pif_flags_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.externalResetPin_n(externalResetPin_n), .watchdogTimeout(watchdogTimeout),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.irqRequest(irqRequest));
`default_nettype wire

// File: pif_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module pif_event_src (
	input  wire logic        core_clk,
	input  wire logic [10:0] fire,
	output var  logic [7:0]  pulse,
	output var  logic        pinLevel,
	output var  logic [7:0]  tzCount,
	output var  logic [3:0]  portPins
);
	initial begin
		pulse = 8'h00;
		pinLevel = 1'b0;
		tzCount = 8'hfd;
		portPins = 4'h0;
	end
	always @(posedge core_clk) begin
		pulse <= fire[7:0];
		if (fire[8]) pinLevel <= !pinLevel;
		if (fire[9]) tzCount <= tzCount + 8'h01;
		if (fire[10]) portPins <= portPins + 4'h1;
	end
endmodule : pif_event_src
`default_nettype wire

// File: tb_peripheral_interrupt_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_interrupt_flags;
	localparam logic [8:0] FL = pif_pkg::IDX_EVENT_FLAGS;
	localparam logic [8:0] EN = pif_pkg::IDX_EVENT_ENABLES;
	localparam logic [8:0] OP = pif_pkg::IDX_OPTION_CTRL;
	localparam logic [8:0] G0 = pif_pkg::IDX_GLOBAL_CTRL_B0;
	localparam logic [7:0] KEEP = ~(8'h01 << pif_pkg::BIT_RESERVED);
	localparam logic [7:0] NA = ~pif_pkg::ASYNC_BITS_MASK;
	logic core_clk = 1'b0, rst_n = 1'b0, externalResetPin_n = 1'b1;
	logic watchdogTimeout = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, capcompMode = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [31:0] hrdataNa;
	logic [2:0] hsize = 3'h0;
	logic hreadyout, hresp, irqRequest, pinLevel;
	logic [10:0] fire = 11'h0;
	logic [7:0] pulse, tzCount;
	logic [3:0] portPins;
	logic [15:0] seed = 16'h5c8c;
	int errors = 0, cmp_count = 0, cyc = 0;
	always #2.5 core_clk = ~core_clk;
	pif_event_src u_src (.core_clk(core_clk), .fire(fire), .pulse(pulse),
		.pinLevel(pinLevel), .tzCount(tzCount), .portPins(portPins));
	pif_flags u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.externalResetPin_n(externalResetPin_n),
		.watchdogTimeout(watchdogTimeout), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .parallelPortAccess(pulse[7]),
		.asyncReceiveEvent(pulse[5]), .asyncTransmitEvent(pulse[4]),
		.syncSerialDone(pulse[3]), .capcompMode(capcompMode),
		.capcompCapture(pulse[2]), .capcompCompareMatch(pulse[6]),
		.timerTwoMatch(pulse[1]), .timerOneOverflow(pulse[0]),
		.externalInterruptPin(pinLevel), .timerZeroCount(tzCount),
		.portChangeInputs(portPins), .irqRequest(irqRequest));
	pif_flags #(.HAS_ASYNC_SERIAL(1'b0)) u_dut_noasync (.core_clk(core_clk),
		.rst_n(rst_n), .externalResetPin_n(externalResetPin_n),
		.watchdogTimeout(watchdogTimeout), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdataNa), .hreadyout(), .hresp(),
		.parallelPortAccess(pulse[7]),
		.asyncReceiveEvent(pulse[5]), .asyncTransmitEvent(pulse[4]),
		.syncSerialDone(pulse[3]), .capcompMode(capcompMode),
		.capcompCapture(pulse[2]), .capcompCompareMatch(pulse[6]),
		.timerTwoMatch(pulse[1]), .timerOneOverflow(pulse[0]),
		.externalInterruptPin(pinLevel), .timerZeroCount(tzCount),
		.portChangeInputs(portPins), .irqRequest());
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] expFlag(input int k, input logic [1:0] m);
		if (k == 6) return (m == pif_pkg::CAPCOMP_COMPARE) ? 8'h04 : 8'h00;
		if (k == 2) return (m == pif_pkg::CAPCOMP_CAPTURE) ? 8'h04 : 8'h00;
		return 8'h01 << k;
	endfunction : expFlag
	task automatic finish_test;
		$display("mismatches %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [8:0] i, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= pif_pkg::HTRANS_NONSEQ;
		haddr <= {21'h0, i, 2'h0};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
	endtask : bus
	task automatic wr(input logic [8:0] i, input logic [7:0] d);
		bus(i, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [8:0] i, input logic [7:0] e);
		bus(i, 1'b0, 8'h00);
		chk(hrdata, {24'h0, e});
		chk(hrdataNa, {24'h0, i == FL ? e & NA : e});
	endtask : rd
	task automatic ev(input int k);
		fire <= 11'h1 << k;
		@(posedge core_clk);
		fire <= 11'h0;
		repeat (4) @(posedge core_clk);
	endtask : ev
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(FL, 8'h00);
		rd(EN, 8'h00);
		rd(G0, 8'h00);
		rd(OP, pif_pkg::OPTION_RESET);
		wr(EN, KEEP);
		rd(EN, 8'hbf);
		for (int n = 0; n < 6; n++) begin
			seed = lfsr(seed);
			wr(EN, seed[7:0] & KEEP);
			rd(EN, seed[7:0] & pif_pkg::PERIPH_IMPL_MASK);
			wr(FL, seed[15:8] & KEEP);
			rd(FL, seed[15:8] & pif_pkg::PERIPH_IMPL_MASK);
		end
		wr(EN, 8'h00);
		for (int m = 0; m < 4; m++) begin
			capcompMode <= m[1:0];
			for (int k = 0; k < 8; k++) begin
				wr(FL, 8'h00);
				ev(k);
				rd(FL, expFlag(k, m[1:0]));
				chk(irqRequest, 32'h0);
			end
		end
		wr(FL, 8'h00);
		wr(EN, 8'h01);
		wr(pif_pkg::IDX_GLOBAL_CTRL_B2, 8'hc0);
		ev(0);
		chk(irqRequest, 32'h1);
		wr(FL, 8'h00);
		repeat (2) @(posedge core_clk);
		chk(irqRequest, 32'h0);
		wr(pif_pkg::IDX_GLOBAL_CTRL_B2, 8'h78);
		rd(G0, 8'h78);
		rd(pif_pkg::IDX_GLOBAL_CTRL_B1, 8'h78);
		rd(pif_pkg::IDX_GLOBAL_CTRL_B3, 8'h78);
		wr(G0, 8'h89);
		repeat (2) @(posedge core_clk);
		chk(irqRequest, 32'h1);
		wr(G0, 8'h81);
		repeat (2) @(posedge core_clk);
		chk(irqRequest, 32'h0);
		wr(G0, 8'h00);
		ev(8);
		for (int n = 0; n < 3; n++) ev(9);
		ev(10);
		rd(G0, 8'h07);
		wr(OP, 8'h00);
		wr(G0, 8'h00);
		ev(8);
		rd(G0, 8'h02);
		wr(G0, 8'h00);
		ev(8);
		rd(G0, 8'h00);
		wr(FL, 8'h8f);
		wr(G0, 8'hf9);
		externalResetPin_n <= 1'b0;
		@(posedge core_clk);
		externalResetPin_n <= 1'b1;
		rd(G0, 8'h01);
		rd(FL, 8'h00);
		rd(OP, pif_pkg::OPTION_RESET);
		wr(G0, 8'hfe);
		watchdogTimeout <= 1'b1;
		@(posedge core_clk);
		watchdogTimeout <= 1'b0;
		rd(G0, 8'h00);
		wr(G0, 8'hff);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(G0, 8'h00);
		wr(9'h00d, 8'hff);
		rd(9'h00d, 8'h00);
		finish_test();
	end
endmodule : tb_peripheral_interrupt_flags
`default_nettype wire
